// *** hw/guard_pkg.sv ***
/*
 sdram_command_timing_guard package: timing minimums in picoseconds (deep power down in microseconds),
 cycle floors, clock period and command encodings.
 assumes a 200 MHz controller clock, with an 18000 ps period before configuration.
*/
package guard_pkg;
  localparam int CLK_PS = 5000;
  localparam int ROW_OPEN_PS = 42000;
  localparam int SB_PRE_PS = 15000;
  localparam int AB_PRE_PS = 18000;
  localparam int SR_LOW_PS = 15000;
  localparam int SR_LOW_FLOOR = 3;
  localparam int REFAB_PS = 130000;
  localparam int SR_EXIT_EXTRA_PS = 10000;
  localparam int XP_PS = 7500;
  localparam int RTP_PS = 7500;
  localparam int WTR_PS = 7500;
  localparam int RRD_PS = 10000;
  localparam int FAW_PS = 50000;
  localparam int DERATE_PS = 1875;
  localparam int FLOOR2 = 2;
  localparam int FLOOR3 = 3;
  localparam int FLOOR8 = 8;
  localparam int MRW_CYC = 5;
  localparam int BOOT_CLK_PS = 18000;
  localparam int DPD_US = 500;
  localparam int FLOOR_LIMIT_PS = 6000;
  localparam int DPD_CYC = DPD_US * 1000000 / CLK_PS;

  function automatic int cyc(input int ps, input int fl, input int per);
    int c;
    c = (ps + per - 1) / per;
    if (per > FLOOR_LIMIT_PS && c < fl) c = fl;
    if (c < 1) c = 1;
    return c;
  endfunction

  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_MRW,
    CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX, CMD_DPE, CMD_DPX
  } cmd_e;
endpackage

// *** hw/sdram_command_timing_guard.sv ***
/*
 sdram_command_timing_guard: host-side guard between a command source and
 the sdram command bus. holds each request until every spacing is met.
 assumes requester keeps cmd stable while cmd_valid and not cmd_ready.
*/
// Overview of operation
// RULE1: same-bank activates spaced by row open plus precharge
// RULE2: self refresh keeps clock enable low long
// RULE3: self refresh exit waits refresh cycle plus 10ns
// RULE4: power down exit waits 7.5ns, two cycles
// RULE5: read to precharge same bank 7.5ns
// RULE6: single bank precharge before reactivation 15ns
// RULE7: all bank precharge before any activate 18ns
// RULE8: write to read gap 7.5ns
// RULE9: cross bank activate gap 10ns
// RULE10: at most four activates per window
// RULE11: deep power down lasts 500us at least
// RULE12: derating adds 1.875ns to core gaps
// RULE13: boot timing until configured
// RULE14: device loads defaults on reset command
// RULE15: counts derive from actual clock period; deep power down count fixed from CLK_PS
// RULE16: cycle floors only above 6ns period
// RULE17: mode register write waits five cycles
// RULE18: round up, then take floor maximum
`timescale 1ns/1ps
`default_nettype none
module sdram_command_timing_guard
  import guard_pkg::*;
#(
  parameter int BANKS = 8,
  parameter int DPD_CYCLES = DPD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic derate_en,
  input wire logic configured,
  input wire logic cmd_valid,
  input wire cmd_e cmd,
  input wire logic [2:0] cmd_bank,
  output logic cmd_ready,
  output logic issue_valid,
  output cmd_e issue_cmd,
  output logic [2:0] issue_bank,
  output logic clk_en
);
  localparam int CW = 20;
  // period used for conversion: boot period until configured
  int per; // RULE13 RULE15
  assign per = configured ? CLK_PS : BOOT_CLK_PS;
  int dr;
  assign dr = derate_en ? DERATE_PS : 0; // RULE12
  // RULE18 RULE16
  logic [CW-1:0] t_rc, t_rp, t_rpa, t_rtp, t_wtr, t_rrd, t_faw;
  logic [CW-1:0] t_cksr, t_xsr, t_xp;
  assign t_rc = CW'(cyc(ROW_OPEN_PS + SB_PRE_PS + dr, FLOOR3, per));
  assign t_rp = CW'(cyc(SB_PRE_PS + dr, FLOOR3, per));
  assign t_rpa = CW'(cyc(AB_PRE_PS + dr, FLOOR3, per));
  assign t_rtp = CW'(cyc(RTP_PS, FLOOR2, per));
  assign t_wtr = CW'(cyc(WTR_PS, FLOOR2, per));
  assign t_rrd = CW'(cyc(RRD_PS + dr, FLOOR2, per));
  assign t_faw = CW'(cyc(FAW_PS, FLOOR8, per));
  assign t_cksr = CW'(cyc(SR_LOW_PS, SR_LOW_FLOOR, per));
  assign t_xsr = CW'(cyc(REFAB_PS + SR_EXIT_EXTRA_PS, FLOOR2, per));
  assign t_xp = CW'(cyc(XP_PS, FLOOR2, per));

  // per-bank counters: activate gap, precharge-to-act, read-to-pre
  logic [CW-1:0] act_ff [BANKS];
  logic [CW-1:0] pre_ff [BANKS];
  logic [CW-1:0] rtp_ff [BANKS];
  logic [CW-1:0] rrd_ff, wtr_ff, glob_ff, low_ff;
  logic [CW-1:0] faw_ff [4];
  logic [1:0] faw_ptr_ff;
  logic [CW-1:0] dpd_ff;
  logic in_sr_ff, in_pd_ff, in_dpd_ff;
  logic lp_lock;

  // low power: only the matching exit is legal
  always_comb begin
    lp_lock = 1'b0;
    if (in_sr_ff && cmd != CMD_SRX) lp_lock = 1'b1; // RULE2
    if (in_pd_ff && cmd != CMD_PDX) lp_lock = 1'b1; // RULE4
    if (in_dpd_ff && cmd != CMD_DPX) lp_lock = 1'b1; // RULE11
    if (!in_sr_ff && cmd == CMD_SRX) lp_lock = 1'b1;
    if (!in_pd_ff && cmd == CMD_PDX) lp_lock = 1'b1;
    if (!in_dpd_ff && cmd == CMD_DPX) lp_lock = 1'b1;
  end

  logic ok;
  logic fire;
  always_comb begin
    ok = (glob_ff == '0) && !lp_lock;
    case (cmd)
      CMD_ACT: begin
        if (act_ff[cmd_bank] != '0) ok = 1'b0; // RULE1
        if (pre_ff[cmd_bank] != '0) ok = 1'b0; // RULE6 RULE7
        if (rrd_ff != '0) ok = 1'b0; // RULE9
        if (faw_ff[faw_ptr_ff] != '0) ok = 1'b0; // RULE10
      end
      CMD_PRE: begin
        if (rtp_ff[cmd_bank] != '0) ok = 1'b0; // RULE5
      end
      CMD_PREA: begin
        for (int i = 0; i < BANKS; i++) begin
          if (rtp_ff[i] != '0) ok = 1'b0;
        end
      end
      CMD_RD: begin
        if (wtr_ff != '0) ok = 1'b0; // RULE8
      end
      CMD_SRX: begin
        if (low_ff != '0) ok = 1'b0; // RULE2
      end
      CMD_DPX: begin
        if (dpd_ff != '0) ok = 1'b0; // RULE11
      end
      default: begin
      end
    endcase
  end
  assign fire = cmd_valid && ok;
  assign cmd_ready = ok;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == '0) ? '0 : v - CW'(1);
  endfunction

  // per-bank activate gap
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < BANKS; i++) begin
      if (!rst_n) begin
        act_ff[i] <= '0;
      end else if (fire && cmd == CMD_ACT && cmd_bank == 3'(i)) begin
        act_ff[i] <= t_rc - CW'(1); // RULE1
      end else begin
        act_ff[i] <= dec(act_ff[i]);
      end
    end
  end

  // per-bank precharge to activate
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < BANKS; i++) begin
      if (!rst_n) begin
        pre_ff[i] <= '0;
      end else if (fire && cmd == CMD_PREA) begin
        pre_ff[i] <= t_rpa - CW'(1); // RULE7
      end else if (fire && cmd == CMD_PRE && cmd_bank == 3'(i)) begin
        pre_ff[i] <= t_rp - CW'(1); // RULE6
      end else begin
        pre_ff[i] <= dec(pre_ff[i]);
      end
    end
  end

  // per-bank read to precharge
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < BANKS; i++) begin
      if (!rst_n) begin
        rtp_ff[i] <= '0;
      end else if (fire && cmd == CMD_RD && cmd_bank == 3'(i)) begin
        rtp_ff[i] <= t_rtp - CW'(1); // RULE5
      end else begin
        rtp_ff[i] <= dec(rtp_ff[i]);
      end
    end
  end

  // cross-bank activate gap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rrd_ff <= '0;
    end else if (fire && cmd == CMD_ACT) begin
      rrd_ff <= t_rrd - CW'(1); // RULE9
    end else begin
      rrd_ff <= dec(rrd_ff);
    end
  end

  // write to read gap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wtr_ff <= '0;
    end else if (fire && cmd == CMD_WR) begin
      wtr_ff <= t_wtr - CW'(1); // RULE8
    end else begin
      wtr_ff <= dec(wtr_ff);
    end
  end

  // ring of last four activate times
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) faw_ff[i] <= '0;
      faw_ptr_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) faw_ff[i] <= dec(faw_ff[i]);
      if (fire && cmd == CMD_ACT) begin
        faw_ff[faw_ptr_ff] <= t_faw - CW'(1); // RULE10
        faw_ptr_ff <= faw_ptr_ff + 2'h1;
      end
    end
  end

  // global gap after mode transitions
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      glob_ff <= '0;
    end else if (fire) begin
      case (cmd)
        CMD_MRW: glob_ff <= CW'(MRW_CYC - 1); // RULE17
        CMD_SRX: glob_ff <= t_xsr - CW'(1); // RULE3
        CMD_PDX: glob_ff <= t_xp - CW'(1); // RULE4
        CMD_DPX: glob_ff <= t_xp - CW'(1);
        default: glob_ff <= dec(glob_ff);
      endcase
    end else begin
      glob_ff <= dec(glob_ff);
    end
  end

  // clock enable: low from any entry until its exit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_en <= 1'b1;
    end else if (fire) begin
      case (cmd)
        CMD_SRE, CMD_PDE, CMD_DPE: clk_en <= 1'b0;
        CMD_SRX, CMD_PDX, CMD_DPX: clk_en <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  // self refresh low residency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_ff <= '0;
    end else if (fire && cmd == CMD_SRE) begin
      low_ff <= t_cksr - CW'(1); // RULE2
    end else begin
      low_ff <= dec(low_ff);
    end
  end

  // deep power down residency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dpd_ff <= '0;
    end else if (fire && cmd == CMD_DPE) begin
      dpd_ff <= CW'(DPD_CYCLES - 1); // RULE11
    end else begin
      dpd_ff <= dec(dpd_ff);
    end
  end

  // low-power state flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_sr_ff <= 1'b0;
    end else if (fire && cmd == CMD_SRE) begin
      in_sr_ff <= 1'b1;
    end else if (fire && cmd == CMD_SRX) begin
      in_sr_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_pd_ff <= 1'b0;
    end else if (fire && cmd == CMD_PDE) begin
      in_pd_ff <= 1'b1;
    end else if (fire && cmd == CMD_PDX) begin
      in_pd_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_dpd_ff <= 1'b0;
    end else if (fire && cmd == CMD_DPE) begin
      in_dpd_ff <= 1'b1;
    end else if (fire && cmd == CMD_DPX) begin
      in_dpd_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      issue_valid <= 1'b0;
      issue_cmd <= CMD_NOP;
      issue_bank <= 3'h0;
    end else begin
      issue_valid <= fire;
      issue_cmd <= fire ? cmd : CMD_NOP;
      issue_bank <= fire ? cmd_bank : 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/guard_asserts.sv ***
/* checker: command spacing seen on the guard's issue port.
 bound to the guard top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module guard_asserts
  import guard_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire cmd_e cmd,
  input wire logic cmd_ready,
  input wire logic issue_valid,
  input wire cmd_e issue_cmd,
  input wire logic [2:0] issue_bank
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] hit;
  assign hit = issue_valid ? 16'h0001 << issue_cmd : 16'h0000;
  chk_take_then_issue: assert property (cmd_valid && cmd_ready |=>
    issue_valid && issue_cmd == $past(cmd)) else $error("issue lost");
  chk_cross_act_gap: assert property (
    hit[CMD_ACT] |=> !hit[CMD_ACT]) else $error("act gap short");
  chk_read_pre_gap: assert property (hit[CMD_RD] |=>
    !(hit[CMD_PRE] && issue_bank == $past(issue_bank)))
    else $error("read to precharge short");
  chk_write_read_gap: assert property (
    hit[CMD_WR] |=> !hit[CMD_RD]) else $error("write to read short");
  chk_prea_act_gap: assert property (
    hit[CMD_PREA] |=> !hit[CMD_ACT] [*3]) else $error("prea gap short");
  chk_config_gap: assert property (
    hit[CMD_MRW] |=> !issue_valid [*4]) else $error("mrw gap short");
  chk_selfref_low: assert property (
    hit[CMD_SRE] |=> !hit[CMD_SRX] [*2]) else $error("sr low short");
  chk_selfref_exit: assert property (
    hit[CMD_SRX] |=> !issue_valid [*7]) else $error("srx wait short");
  chk_pd_exit: assert property (
    hit[CMD_PDX] |=> !issue_valid) else $error("pdx wait short");
endmodule
bind sdram_command_timing_guard guard_asserts u_chk (.*);
`default_nettype wire

// *** testbench/sdram_model.sv ***
/* device model: open rows and config defaults.
 fed by the guard's issue outputs and clock enable. */
`timescale 1ns/1ps
`default_nettype none
module sdram_model
  import guard_pkg::*;
#(
  parameter logic [7:0] CFG_DEFAULT = 8'h5A
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire cmd_e issue_cmd,
  input wire logic [2:0] issue_bank,
  input wire logic clk_en,
  output logic [7:0] open_ff,
  output logic [7:0] cfg_ff
);
  // reset or a mode register write command reloads defaults
  always_ff @(posedge sys_clk) begin
    if (!rst_n || issue_valid && issue_cmd == CMD_MRW) begin
      cfg_ff <= CFG_DEFAULT;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || issue_valid && issue_cmd == CMD_PREA) begin
      open_ff <= 8'h00;
    end else if (issue_valid && clk_en) begin
      if (issue_cmd == CMD_ACT) open_ff[issue_bank] <= 1'b1;
      if (issue_cmd == CMD_PRE) open_ff[issue_bank] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/sdram_command_timing_guard_tb_top.sv ***
/* testbench: spacing scenarios through the guard command port.
 uses the device model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module sdram_command_timing_guard_tb_top
  import guard_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, derate_en = 0, configured = 1;
  logic cmd_valid = 0, cmd_ready, issue_valid, clk_en;
  logic [2:0] cmd_bank = 0, issue_bank;
  logic [7:0] open_ff, cfg_ff;
  cmd_e cmd = CMD_NOP, issue_cmd;
  int fails = 0, cmp_count = 0, n;
  always #2.5 sys_clk = ~sys_clk;
  sdram_command_timing_guard #(.DPD_CYCLES(20)) uut (.*);
  sdram_model dev (.*);
  function automatic int g(int ps, int fl, int per);
    g = (ps + per - 1) / per;
    if (per > FLOOR_LIMIT_PS && g < fl) g = fl;
  endfunction
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", s, e, v);
    end
  endtask
  // n counts edges until the command is taken
  task automatic send(cmd_e c, logic [2:0] b);
    cmd_valid = 1;
    cmd = c;
    cmd_bank = b;
    n = 1;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      report_and_stop();
    end
    @(posedge sys_clk);
    #1;
    chk("issue_cmd", c, issue_cmd);
    chk("issue_bank", b, issue_bank);
  endtask
  task automatic idle(int k);
    cmd_valid = 0;
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_act();
    send(CMD_ACT, 0);
    send(CMD_ACT, 1);
    chk("rrd", g(RRD_PS, FLOOR2, CLK_PS), n);
    send(CMD_ACT, 0);
    chk("rc", g(ROW_OPEN_PS + SB_PRE_PS, 1, CLK_PS) - 2, n);
    send(CMD_WR, 0);
    chk("open", 8'h03, open_ff);
    send(CMD_RD, 0);
    chk("wtr", g(WTR_PS, FLOOR2, CLK_PS), n);
    send(CMD_PRE, 0);
    chk("rtp", g(RTP_PS, FLOOR2, CLK_PS), n);
    idle(40);
  endtask
  task automatic t_faw();
    for (int i = 1; i < 6; i++) send(CMD_ACT, i[2:0]);
    chk("faw", g(FAW_PS, FLOOR8, CLK_PS) - 6, n);
    idle(20);
    send(CMD_PRE, 2);
    send(CMD_ACT, 2);
    chk("rp", g(SB_PRE_PS, FLOOR3, CLK_PS), n);
    idle(20);
    send(CMD_PREA, 0);
    derate_en = 1;
    send(CMD_ACT, 3);
    chk("rpab", g(AB_PRE_PS, FLOOR3, CLK_PS), n);
    send(CMD_ACT, 4);
    chk("rrd_der", g(RRD_PS + DERATE_PS, FLOOR2, CLK_PS), n);
    send(CMD_ACT, 4);
    chk("rc_der", g(ROW_OPEN_PS + SB_PRE_PS + DERATE_PS, 1, CLK_PS), n);
    idle(20);
    derate_en = 0;
  endtask
  task automatic t_modes(int per);
    send(CMD_MRW, 0);
    send(CMD_PDE, 0);
    chk("mrw", MRW_CYC, n);
    chk("cfg", 8'h5A, cfg_ff);
    send(CMD_PDX, 0);
    send(CMD_ACT, 5);
    chk("pdx", g(XP_PS, FLOOR2, per), n);
    idle(20);
    send(CMD_SRE, 0);
    chk("cke_low", 0, clk_en);
    send(CMD_SRX, 0);
    chk("sr_low", g(SR_LOW_PS, SR_LOW_FLOOR, per), n);
    send(CMD_ACT, 6);
    chk("srx", g(REFAB_PS + SR_EXIT_EXTRA_PS, FLOOR2, per), n);
    chk("cke_high", 1, clk_en);
    send(CMD_DPE, 0);
    send(CMD_DPX, 0);
    chk("dpd", 20, n);
    idle(20);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1;
    idle(2);
    t_act();
    t_faw();
    t_modes(CLK_PS);
    configured = 0;
    t_modes(BOOT_CLK_PS);
    report_and_stop();
  end
endmodule
`default_nettype wire
